// ---- src/sasc_pkg.sv ----
// Package for the auxiliary serial status and control block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package sasc_pkg;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam int BIT_BRK_FLAG = 7;
  localparam int BIT_EDGE_FLAG = 6;
  localparam int BIT_RX_INVERT = 4;
  localparam int BIT_WAKE_SEL = 3;
  localparam int BIT_LONG_BREAK = 2;
  localparam int BIT_BRK_DET_EN = 1;
  localparam int BIT_RX_ACTIVE = 0;
  localparam int BIT_RX_NINTH = 7;
  localparam int BIT_TX_NINTH = 6;
  localparam int BIT_SW_DIR = 5;
  localparam int BIT_TX_INVERT = 4;
  localparam int BIT_LOOP_SEL = 0;
  localparam int BIT_RX_SOURCE_SELECT_SEL = 1;
  localparam int BIT_NINE_BIT = 2;
  localparam logic [3:0] IE_RESET = 4'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [3:0] BRK_DET_SHORT = 4'hA;
  localparam logic [3:0] BRK_DET_LONG = 4'hB;
  localparam logic [3:0] TX_BRK_SHORT = 4'hA;
  localparam logic [3:0] TX_BRK_LONG = 4'hD;
  localparam logic [3:0] BRK_CNT_MAX = 4'hF;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sasc_wb_req_s;

  typedef struct packed {
    logic bit_tick;
    logic start_seen;
    logic idle_seen;
    logic char_done;
    logic stop_zero;
    logic ninth_in;
    logic buf_full;
    logic standby;
  } sasc_rx_evt_s;

  typedef struct packed {
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } sasc_err_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic brk_flag;
    logic edge_flag;
    logic rx_invert;
    logic wake_sel;
    logic long_break;
    logic brk_det_en;
    logic rx_active;
    logic rx_ninth;
    logic tx_ninth;
    logic sw_dir;
    logic tx_invert;
    logic [3:0] ie;
    logic [1:0] irq_mask;
    logic loop_sel;
    logic rx_source_select_sel;
    logic nine_bit;
    logic rx_prev;
    logic [3:0] brk_cnt;
    logic irq;
    logic err_irq;
    logic tx_pin_out;
    logic tx_pin_oe;
    logic fe_set;
    logic full_set;
    logic idle_set;
    logic [3:0] tx_brk_len;
  } sasc_state_s;
endpackage

// ---- src/sasc_aux.sv ----
// Auxiliary status and control logic of an asynchronous serial port.
// Assumes the receive core, baud ticks and pins are synchronous to sys_clk.
`timescale 1ns/1ps
module sasc_aux (
  input wire logic sys_clk,
  input wire logic rst_n,
  input sasc_pkg::sasc_wb_req_s wb_req,
  output logic wb_ack,
  output logic [31:0] wb_rdata,
  input sasc_pkg::sasc_rx_evt_s rx_evt,
  input sasc_pkg::sasc_err_s err_flags,
  input wire logic rx_pin,
  input wire logic tx_core,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic rx_line,
  output logic fe_set,
  output logic rx_full_set,
  output logic idle_set,
  output logic rx_ninth_bit,
  output logic tx_ninth_bit,
  output logic [3:0] tx_brk_len,
  output logic irq,
  output logic err_irq
);
  sasc_pkg::sasc_state_s cur;
  sasc_pkg::sasc_state_s nxt;
  logic line_now;
  logic wr_now;
  logic [7:0] wd;
  logic [3:0] thr;
  logic brk_hit;
  logic load_char;

  always_comb begin
    nxt = cur;
    // The receive source follows loop mode; inversion covers all uses.
    if (!cur.loop_sel) begin
      line_now = rx_pin ^ cur.rx_invert;
    end else if (cur.rx_source_select_sel) begin
      line_now = tx_pin_in ^ cur.rx_invert;
    end else begin
      line_now = (tx_core ^ cur.tx_invert) ^ cur.rx_invert;
    end
    wr_now = wb_req.cyc && wb_req.stb && wb_req.we && cur.ack && wb_req.sel[0];
    wd = wb_req.dat[7:0];
    // Threshold grows by one with the enable and with nine-bit frames.
    thr = (cur.brk_det_en ? sasc_pkg::BRK_DET_LONG : sasc_pkg::BRK_DET_SHORT)
        + {3'h0, cur.nine_bit};
    brk_hit = rx_evt.bit_tick && !line_now && ((cur.brk_cnt + 4'h1) == thr);
    load_char = rx_evt.char_done && !cur.brk_det_en && !rx_evt.buf_full;
    nxt.rx_prev = line_now;
    if (rx_evt.bit_tick) begin
      if (line_now) begin
        nxt.brk_cnt = 4'h0;
      end else if (cur.brk_cnt != sasc_pkg::BRK_CNT_MAX) begin
        nxt.brk_cnt = cur.brk_cnt + 4'h1;
      end
    end
    nxt.ack = wb_req.cyc && wb_req.stb && !cur.ack;
    nxt.rdat = 8'h00;
    if (wb_req.cyc && wb_req.stb && !cur.ack && !wb_req.we) begin
      unique case (wb_req.adr)
        sasc_pkg::OFS_STATUS: begin
          nxt.rdat = {cur.brk_flag, cur.edge_flag, 1'b0, cur.rx_invert, cur.wake_sel,
                      cur.long_break, cur.brk_det_en, cur.rx_active};
        end
        sasc_pkg::OFS_CONTROL: begin
          nxt.rdat = {cur.rx_ninth, cur.tx_ninth, cur.sw_dir, cur.tx_invert, cur.ie};
        end
        sasc_pkg::OFS_IRQ_MASK: begin
          nxt.rdat = {cur.irq_mask, 6'h00};
        end
        sasc_pkg::OFS_MODE: begin
          nxt.rdat = {5'h00, cur.nine_bit, cur.rx_source_select_sel, cur.loop_sel};
        end
        default: begin
          nxt.rdat = 8'h00;
        end
      endcase
    end
    if (wr_now) begin
      unique case (wb_req.adr)
        sasc_pkg::OFS_STATUS: begin
          if (wd[sasc_pkg::BIT_BRK_FLAG]) begin
            nxt.brk_flag = 1'b0;
          end
          if (wd[sasc_pkg::BIT_EDGE_FLAG]) begin
            nxt.edge_flag = 1'b0;
          end
          nxt.rx_invert = wd[sasc_pkg::BIT_RX_INVERT];
          nxt.wake_sel = wd[sasc_pkg::BIT_WAKE_SEL];
          nxt.long_break = wd[sasc_pkg::BIT_LONG_BREAK];
          nxt.brk_det_en = wd[sasc_pkg::BIT_BRK_DET_EN];
        end
        sasc_pkg::OFS_CONTROL: begin
          nxt.tx_ninth = wd[sasc_pkg::BIT_TX_NINTH];
          nxt.sw_dir = wd[sasc_pkg::BIT_SW_DIR];
          nxt.tx_invert = wd[sasc_pkg::BIT_TX_INVERT];
          nxt.ie = wd[3:0];
        end
        sasc_pkg::OFS_IRQ_MASK: begin
          nxt.irq_mask = wd[7:6];
        end
        sasc_pkg::OFS_MODE: begin
          nxt.loop_sel = wd[sasc_pkg::BIT_LOOP_SEL];
          nxt.rx_source_select_sel = wd[sasc_pkg::BIT_RX_SOURCE_SELECT_SEL];
          nxt.nine_bit = wd[sasc_pkg::BIT_NINE_BIT];
        end
        default: begin
        end
      endcase
    end
    // Hardware sets win over a write-one clear in the same cycle.
    if (brk_hit && cur.brk_det_en) begin
      nxt.brk_flag = 1'b1;
    end
    if (cur.rx_prev && !line_now) begin
      nxt.edge_flag = 1'b1;
    end
    if (rx_evt.idle_seen) begin
      nxt.rx_active = 1'b0;
    end else if (rx_evt.start_seen) begin
      nxt.rx_active = 1'b1;
    end
    if (load_char) begin
      nxt.rx_ninth = rx_evt.ninth_in;
    end
    // Framing is raised only together with buffer-full; neither is raised under break detect.
    nxt.fe_set = rx_evt.char_done && rx_evt.stop_zero && !cur.brk_det_en;
    nxt.full_set = rx_evt.char_done && !cur.brk_det_en;
    nxt.idle_set = rx_evt.idle_seen && (!rx_evt.standby || cur.wake_sel);
    nxt.tx_brk_len = (cur.long_break ? sasc_pkg::TX_BRK_LONG : sasc_pkg::TX_BRK_SHORT)
                   + {3'h0, cur.nine_bit};
    nxt.tx_pin_out = tx_core ^ cur.tx_invert;
    nxt.tx_pin_oe = !(cur.loop_sel && cur.rx_source_select_sel && !cur.sw_dir);
    nxt.err_irq = (err_flags.overrun && cur.ie[3])
                || (err_flags.noise && cur.ie[2])
                || (err_flags.framing && cur.ie[1])
                || (err_flags.parity && cur.ie[0]);
    nxt.irq = |({nxt.brk_flag, nxt.edge_flag} & cur.irq_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= '0;
      cur.rx_prev <= 1'b1;
      cur.tx_pin_out <= 1'b1;
      cur.tx_pin_oe <= 1'b1;
      cur.ie <= sasc_pkg::IE_RESET;
      cur.irq_mask <= sasc_pkg::MASK_RESET;
      cur.tx_brk_len <= sasc_pkg::TX_BRK_SHORT;
    end else begin
      cur <= nxt;
    end
  end

  assign wb_ack = cur.ack;
  assign wb_rdata = {24'h000000, cur.rdat};
  assign tx_pin_out = cur.tx_pin_out;
  assign tx_pin_oe = cur.tx_pin_oe;
  assign rx_line = cur.rx_prev;
  assign fe_set = cur.fe_set;
  assign rx_full_set = cur.full_set;
  assign idle_set = cur.idle_set;
  assign rx_ninth_bit = cur.rx_ninth;
  assign tx_ninth_bit = cur.tx_ninth;
  assign tx_brk_len = cur.tx_brk_len;
  assign irq = cur.irq;
  assign err_irq = cur.err_irq;

  property p_brk_needs_en;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(cur.brk_flag) |-> $past(cur.brk_det_en) && $past(brk_hit);
  endproperty
  a_brk_needs_en: assert property (p_brk_needs_en) else $error("break flag without enable");

  property p_edge_sets;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.rx_prev && !line_now) |=> cur.edge_flag;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge flag not set");

  property p_rx_invert;
    @(posedge sys_clk) disable iff (!rst_n)
    (!cur.loop_sel && cur.rx_invert) |=> (rx_line != $past(rx_pin));
  endproperty
  a_rx_invert: assert property (p_rx_invert) else $error("receive line not inverted");

  property p_wake_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.idle_seen && rx_evt.standby && !cur.wake_sel) |=> !idle_set;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("idle set during standby");

  property p_long_break;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.long_break && !cur.nine_bit) |=> (tx_brk_len == 4'hD);
  endproperty
  a_long_break: assert property (p_long_break) else $error("long break length wrong");

  property p_brk_thr;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.bit_tick && !line_now && cur.brk_det_en && !cur.nine_bit && cur.brk_cnt == 4'hA)
      |=> cur.brk_flag;
  endproperty
  a_brk_thr: assert property (p_brk_thr) else $error("break threshold wrong");

  property p_no_fe_in_brk;
    @(posedge sys_clk) disable iff (!rst_n)
    (fe_set || rx_full_set) |-> !$past(cur.brk_det_en);
  endproperty
  a_no_fe_in_brk: assert property (p_no_fe_in_brk) else $error("flag set under break detect");

  property p_active;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.start_seen && !rx_evt.idle_seen) |=> cur.rx_active;
  endproperty
  a_active: assert property (p_active) else $error("receiver active not set");

  property p_idle_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    rx_evt.idle_seen |=> !cur.rx_active;
  endproperty
  a_idle_clears: assert property (p_idle_clears) else $error("active not cleared on idle");

  property p_ninth;
    @(posedge sys_clk) disable iff (!rst_n)
    load_char |=> (rx_ninth_bit == $past(rx_evt.ninth_in));
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit not captured");

  property p_single_wire;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.loop_sel && cur.rx_source_select_sel) |=> (tx_pin_oe == $past(cur.sw_dir));
  endproperty
  a_single_wire: assert property (p_single_wire) else $error("single-wire direction wrong");

  property p_tx_invert;
    @(posedge sys_clk) disable iff (!rst_n)
    cur.tx_invert |=> (tx_pin_out != $past(tx_core));
  endproperty
  a_tx_invert: assert property (p_tx_invert) else $error("transmit not inverted");

  property p_err_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    (|({err_flags.overrun, err_flags.noise, err_flags.framing, err_flags.parity} & cur.ie))
      |=> err_irq;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error request missing");

  property p_err_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.ie == 4'h0) |=> !err_irq;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error request while disabled");

  property p_fe_pair;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.char_done && rx_evt.stop_zero && !cur.brk_det_en) |=> fe_set && rx_full_set;
  endproperty
  a_fe_pair: assert property (p_fe_pair) else $error("framing pair missing");

  property p_ack_one;
    @(posedge sys_clk) disable iff (!rst_n)
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

  property p_brk_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_now && wb_req.adr == sasc_pkg::OFS_STATUS && wd[sasc_pkg::BIT_BRK_FLAG]
      && !brk_hit) |=> !cur.brk_flag;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("break flag not cleared");

  property p_brk_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.brk_flag && !(wr_now && wb_req.adr == sasc_pkg::OFS_STATUS
      && wd[sasc_pkg::BIT_BRK_FLAG])) |=> cur.brk_flag;
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break flag lost");

  property p_edge_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_now && wb_req.adr == sasc_pkg::OFS_STATUS && wd[sasc_pkg::BIT_EDGE_FLAG]
      && !(cur.rx_prev && !line_now)) |=> !cur.edge_flag;
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");

  property p_edge_cause;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(cur.edge_flag) |-> $past(cur.rx_prev) && !$past(line_now);
  endproperty
  a_edge_cause: assert property (p_edge_cause) else $error("edge flag without edge");

  property p_rx_plain;
    @(posedge sys_clk) disable iff (!rst_n)
    (!cur.loop_sel && !cur.rx_invert) |=> (rx_line == $past(rx_pin));
  endproperty
  a_rx_plain: assert property (p_rx_plain) else $error("receive line altered");

  property p_wake_loud;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.idle_seen && (!rx_evt.standby || cur.wake_sel)) |=> idle_set;
  endproperty
  a_wake_loud: assert property (p_wake_loud) else $error("idle not reported");

  property p_short_break;
    @(posedge sys_clk) disable iff (!rst_n)
    (!cur.long_break && !cur.nine_bit) |=> (tx_brk_len == sasc_pkg::TX_BRK_SHORT);
  endproperty
  a_short_break: assert property (p_short_break) else $error("short break length wrong");

  property p_nine_break;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.long_break && cur.nine_bit) |=> (tx_brk_len == 4'hE);
  endproperty
  a_nine_break: assert property (p_nine_break) else $error("nine-bit break length wrong");

  property p_brk_early;
    @(posedge sys_clk) disable iff (!rst_n)
    (cur.brk_det_en && !cur.nine_bit && cur.brk_cnt < 4'hA) |-> !brk_hit;
  endproperty
  a_brk_early: assert property (p_brk_early) else $error("break detected too early");

  property p_brk_thr_nine;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.bit_tick && !line_now && cur.brk_det_en && cur.nine_bit && cur.brk_cnt == 4'hB)
      |=> cur.brk_flag;
  endproperty
  a_brk_thr_nine: assert property (p_brk_thr_nine) else $error("nine-bit break missed");

  property p_fe_only_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.char_done && !rx_evt.stop_zero) |=> !fe_set;
  endproperty
  a_fe_only_zero: assert property (p_fe_only_zero) else $error("framing without zero stop");

  property p_full_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    (rx_evt.char_done && !cur.brk_det_en) |=> rx_full_set;
  endproperty
  a_full_pulse: assert property (p_full_pulse) else $error("buffer full not raised");

  property p_tx_plain;
    @(posedge sys_clk) disable iff (!rst_n)
    !cur.tx_invert |=> (tx_pin_out == $past(tx_core));
  endproperty
  a_tx_plain: assert property (p_tx_plain) else $error("transmit altered");

  property p_oe_other;
    @(posedge sys_clk) disable iff (!rst_n)
    !(cur.loop_sel && cur.rx_source_select_sel) |=> tx_pin_oe;
  endproperty
  a_oe_other: assert property (p_oe_other) else $error("transmit pin not driven");

  property p_tx_ninth;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_now && wb_req.adr == sasc_pkg::OFS_CONTROL && wd[sasc_pkg::BIT_TX_NINTH])
      |=> tx_ninth_bit;
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("ninth transmit bit lost");
endmodule

// ---- dv/sasc_remote_node.sv ----
// Remote serial node: drives the receive pin low for a counted number of bit times.
// Assumes the bench holds req until busy rises; bit_tick marks each bit sample point.
`timescale 1ns/1ps
module sasc_remote_node (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [3:0] nbits,
  output logic rx_pin,
  output logic bit_tick,
  output logic busy
);
  logic [1:0] ph;
  logic [3:0] left;
  assign bit_tick = (ph == 2'h3);
  assign rx_pin = ~busy;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ph <= 2'h0;
      left <= 4'h0;
      busy <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      if (req && !busy && ph == 2'h0) begin
        busy <= 1'b1;
        left <= nbits;
      end
      // Line is held low for exactly nbits sample points.
      if (busy && ph == 2'h3) begin
        left <= left - 4'h1;
      end
      if (busy && left == 4'h0 && ph == 2'h1) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- dv/serial_aux_status_control_bench.sv ----
// Self-checking bench for the auxiliary serial status and control block.
// Assumes a remote node model on the receive pin and Wishbone register access.
`timescale 1ns/1ps
module serial_aux_status_control_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  sasc_pkg::sasc_wb_req_s wb_req = '0;
  sasc_pkg::sasc_rx_evt_s evt = '0;
  sasc_pkg::sasc_rx_evt_s evt_in;
  sasc_pkg::sasc_err_s err_flags = '0;
  logic tx_core = 1'b0;
  logic req = 1'b0;
  logic [3:0] nbits = 4'h0;
  logic wb_ack, tx_pin_out, tx_pin_oe, rx_line, fe_set, rx_full_set, idle_set;
  logic rx_ninth_bit, tx_ninth_bit, irq, err_irq, rx_pin, tick, busy, tx_pin_in;
  logic [31:0] wb_rdata;
  logic [3:0] tx_brk_len;
  logic [7:0] q;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  always_comb begin
    evt_in = evt;
    evt_in.bit_tick = evt.bit_tick | tick;
  end
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
  sasc_aux dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_rdata(wb_rdata), .rx_evt(evt_in), .err_flags(err_flags), .rx_pin(rx_pin),
    .tx_core(tx_core), .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .rx_line(rx_line), .fe_set(fe_set), .rx_full_set(rx_full_set),
    .idle_set(idle_set), .rx_ninth_bit(rx_ninth_bit), .tx_ninth_bit(tx_ninth_bit),
    .tx_brk_len(tx_brk_len), .irq(irq), .err_irq(err_irq));
  sasc_remote_node node (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .nbits(nbits),
    .rx_pin(rx_pin), .bit_tick(tick), .busy(busy));
  task results;
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results;
    end
  end
  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h000000, d}};
    @(posedge sys_clk);
    while (wb_ack !== 1'b1) @(posedge sys_clk);
    q = wb_rdata[7:0];
    wb_req <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk_reg(q, exp);
  endtask
  task settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task pulse(input logic [7:0] v);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= '0;
    #1;
  endtask
  task brk(input logic [3:0] n);
    @(posedge sys_clk);
    req <= 1'b1;
    nbits <= n;
    while (busy !== 1'b1) @(posedge sys_clk);
    req <= 1'b0;
    settle;
  endtask
  task brk_end;
    while (busy !== 1'b0) @(posedge sys_clk);
    settle;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h00);
    chk_pin({tx_pin_oe, tx_brk_len[2:0]}, 4'hA);
    xfer(1'b1, 8'h04, 8'h50);
    settle;
    chk_pin({tx_pin_out, tx_ninth_bit}, 4'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      err_flags <= 4'(1 << i);
      xfer(1'b1, 8'h04, 8'(~(1 << i) & 4'hF));
      settle;
      chk_pin({3'h0, err_irq}, 4'h0);
      xfer(1'b1, 8'h04, 8'(1 << i));
      settle;
      chk_pin({3'h0, err_irq}, 4'h1);
    end
    @(posedge sys_clk);
    err_flags <= '0;
    pulse(8'h18);
    chk_pin({2'h0, fe_set, rx_full_set}, 4'h3);
    xfer(1'b1, 8'h00, 8'h02);
    pulse(8'h1C);
    chk_pin({1'b0, fe_set, rx_full_set, rx_ninth_bit}, 4'h0);
    brk(4'hA);
    brk_end;
    rd(8'h00, 8'h42);
    brk(4'hB);
    brk_end;
    rd(8'h00, 8'hC2);
    chk_pin({3'h0, irq}, 4'h0);
    xfer(1'b1, 8'h08, 8'h80);
    rd(8'h08, 8'h80);
    settle;
    chk_pin({3'h0, irq}, 4'h1);
    xfer(1'b1, 8'h00, 8'hC2);
    settle;
    chk_pin({3'h0, irq}, 4'h0);
    rd(8'h00, 8'h02);
    xfer(1'b1, 8'h00, 8'h10);
    xfer(1'b1, 8'h00, 8'h50);
    rd(8'h00, 8'h10);
    brk(4'h3);
    chk_pin({3'h0, rx_line}, 4'h1);
    brk_end;
    rd(8'h00, 8'h50);
    xfer(1'b1, 8'h00, 8'h40);
    pulse(8'h40);
    rd(8'h00, 8'h01);
    pulse(8'h20);
    rd(8'h00, 8'h00);
    pulse(8'h21);
    chk_pin({3'h0, idle_set}, 4'h0);
    xfer(1'b1, 8'h00, 8'h08);
    pulse(8'h21);
    chk_pin({3'h0, idle_set}, 4'h1);
    xfer(1'b1, 8'h00, 8'h00);
    pulse(8'h14);
    chk_pin({3'h0, rx_ninth_bit}, 4'h1);
    rd(8'h04, 8'h88);
    xfer(1'b1, 8'h00, 8'h04);
    settle;
    chk_pin(tx_brk_len, 4'hD);
    xfer(1'b1, 8'h0C, 8'h07);
    settle;
    chk_pin({tx_pin_oe, 3'h0}, 4'h0);
    chk_pin(tx_brk_len, 4'hE);
    xfer(1'b1, 8'h04, 8'h20);
    settle;
    chk_pin({tx_pin_oe, 3'h0}, 4'h8);
    xfer(1'b1, 8'h0C, 8'h04);
    xfer(1'b1, 8'h00, 8'h42);
    brk(4'hB);
    brk_end;
    rd(8'h00, 8'h42);
    brk(4'hC);
    brk_end;
    rd(8'h00, 8'hC2);
    rd(8'h0C, 8'h04);
    results;
  end
endmodule
